//--- src/cmi_top.sv
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: Flag bits 3 and 2 read zero
// R2: Bit 1 read-only unread flag, resets 0
// R3: Unread flag sets when any status bit sets
// R4: Unread flag clears only when status all clear
// R5: Bit 0 mailbox-empty flag, resets 0
// R6: Empty flag sets when a pending bit clears
// R7: Writing one clears empty flag; zero ignored
// R8: Software reads flag back after clearing
// R9: Mailbox mask bit 0 passes its request
// R10: Mailbox mask bit 1 blocks its request
// R11: Transmit event is pending bit clearing
// R12: Receive event is completion bit setting
// R13: General mask bits gate the flag requests
// R14: Receive flag needs unmasked mailbox completion
// R15: Mailbox mask resets ones, byte-swapped mailbox order
// R16: Request equals flag and not mask
module cmi_top (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic [15:0] TX_PENDING_BITS_IN,
  input wire logic [15:0] RX_COMPLETE_BITS_IN,
  input wire logic [15:0] UNREAD_STATUS_IN,
  output logic UNREAD_REQ_OUT,
  output logic EMPTY_REQ_OUT,
  output logic RXMSG_REQ_OUT,
  output logic [15:0] MBOX_EVT_OUT,
  output logic IRQ_OUT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cmi_pkg::cmi_mbox_t mbox_in;
  cmi_pkg::cmi_flags_t flags_q;
  cmi_pkg::cmi_flags_t flags_d;
  cmi_pkg::cmi_flags_t req_q;
  cmi_pkg::cmi_flags_t req_d;
  logic [15:0] mbox_mask_q;
  logic [15:0] mbox_mask_d;
  logic [15:0] gen_mask_q;
  logic [15:0] gen_mask_d;
  logic [15:0] mbox_mask_vec;
  logic [15:0] mbox_evt_q;
  logic [15:0] mbox_evt_d;
  logic [15:0] tx_fall;
  logic [15:0] rx_rise;
  logic [15:0] um_rise;
  logic [15:0] irq_status;
  logic [15:0] irq_enable;
  logic [15:0] byte_mask;
  logic [15:0] wdata;
  logic [15:0] rd_word;
  logic [15:0] flags_word;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic ack_q;
  logic ack_d;
  logic bus_req;
  logic wr_now;
  logic hit_flags;
  logic hit_mbox;
  logic hit_gen;
  logic hit_stat;
  logic hit_clr;
  logic hit_en;
  logic clr_wr;
  logic en_wr;
  logic empty_clr;

  assign mbox_in = '{tx_pend: TX_PENDING_BITS_IN, rx_done: RX_COMPLETE_BITS_IN,
                     unread: UNREAD_STATUS_IN};

  // ----------------------------------------------------------------
  // Bus slave decode
  // ----------------------------------------------------------------
  // Ack one cycle after the request; write lands on the acking edge
  assign bus_req = WB_CYC_IN & WB_STB_IN & ~ack_q;
  assign wr_now = WB_CYC_IN & WB_STB_IN & ack_q & WB_WE_IN;
  assign byte_mask = {{8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
  assign wdata = WB_DAT_IN[15:0];

  always_comb begin
    hit_flags = 1'b0;
    hit_mbox = 1'b0;
    hit_gen = 1'b0;
    hit_stat = 1'b0;
    hit_clr = 1'b0;
    hit_en = 1'b0;
    if (WB_ADR_IN == cmi_pkg::CMI_OFF_FLAGS) begin
      hit_flags = 1'b1;
    end else if (WB_ADR_IN == cmi_pkg::CMI_OFF_MBOX_MASK) begin
      hit_mbox = 1'b1;
    end else if (WB_ADR_IN == cmi_pkg::CMI_OFF_GEN_MASK) begin
      hit_gen = 1'b1;
    end else if (WB_ADR_IN == cmi_pkg::CMI_OFF_IRQ_STATUS) begin
      hit_stat = 1'b1;
    end else if (WB_ADR_IN == cmi_pkg::CMI_OFF_IRQ_CLEAR) begin
      hit_clr = 1'b1;
    end else if (WB_ADR_IN == cmi_pkg::CMI_OFF_IRQ_ENABLE) begin
      hit_en = 1'b1;
    end
  end

  assign clr_wr = wr_now & hit_clr;
  assign en_wr = wr_now & hit_en;

  // ----------------------------------------------------------------
  // Edge detection on mailbox status
  // ----------------------------------------------------------------
  cmi_edge #(.W(cmi_pkg::CMI_NUM_MBOX)) u_tx_edge (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .sig_in(mbox_in.tx_pend),
    .rise_out(),
    .fall_out(tx_fall)
  );

  cmi_edge #(.W(cmi_pkg::CMI_NUM_MBOX)) u_rx_edge (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .sig_in(mbox_in.rx_done),
    .rise_out(rx_rise),
    .fall_out()
  );

  cmi_edge #(.W(cmi_pkg::CMI_NUM_MBOX)) u_um_edge (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .sig_in(mbox_in.unread),
    .rise_out(um_rise),
    .fall_out()
  );

  // ----------------------------------------------------------------
  // Flags and masks
  // ----------------------------------------------------------------
  // Register holds mailboxes 7..0 in the high byte
  assign mbox_mask_vec = {mbox_mask_q[7:0], mbox_mask_q[15:8]}; // [R15]
  assign empty_clr = wr_now & hit_flags & WB_SEL_IN[0] & wdata[cmi_pkg::CMI_BIT_EMPTY];

  always_comb begin
    flags_d = flags_q;
    if (|um_rise) begin
      flags_d.unread = 1'b1; // [R3]
    end else if (mbox_in.unread == 16'h0000) begin
      flags_d.unread = 1'b0; // [R4]
    end
    if (|tx_fall) begin
      flags_d.empty = 1'b1; // [R6]
    end else if (empty_clr) begin
      flags_d.empty = 1'b0; // [R7]
    end
    if (|(rx_rise & ~mbox_mask_vec)) begin
      flags_d.rx_msg = 1'b1; // [R14]
    end else if (mbox_in.rx_done == 16'h0000) begin
      flags_d.rx_msg = 1'b0;
    end
    mbox_mask_d = mbox_mask_q;
    if (wr_now & hit_mbox) begin
      mbox_mask_d = (mbox_mask_q & ~byte_mask) | (wdata & byte_mask);
    end
    gen_mask_d = gen_mask_q;
    if (wr_now & hit_gen) begin
      gen_mask_d = (gen_mask_q & ~(byte_mask & cmi_pkg::CMI_GEN_MASK_WR))
                 | (wdata & byte_mask & cmi_pkg::CMI_GEN_MASK_WR);
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      flags_q <= '0; // [R2] [R5]
      mbox_mask_q <= cmi_pkg::CMI_MBOX_MASK_RST; // [R15]
      gen_mask_q <= cmi_pkg::CMI_GEN_MASK_RST;
    end else begin
      flags_q <= flags_d;
      mbox_mask_q <= mbox_mask_d;
      gen_mask_q <= gen_mask_d;
    end
  end

  // ----------------------------------------------------------------
  // Requests
  // ----------------------------------------------------------------
  always_comb begin
    req_d.unread = flags_q.unread & ~gen_mask_q[cmi_pkg::CMI_GM_UNREAD]; // [R13] [R16]
    req_d.empty = flags_q.empty & ~gen_mask_q[cmi_pkg::CMI_GM_EMPTY]; // [R13] [R16]
    req_d.rx_msg = flags_q.rx_msg & ~gen_mask_q[cmi_pkg::CMI_GM_RXMSG]; // [R16]
    mbox_evt_d = (tx_fall | rx_rise) & ~mbox_mask_vec; // [R9] [R10] [R11] [R12]
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      req_q <= '0;
      mbox_evt_q <= '0;
    end else begin
      req_q <= req_d;
      mbox_evt_q <= mbox_evt_d;
    end
  end

  // Mailbox events latch here until software clears them
  cmi_sticky #(.W(cmi_pkg::CMI_NUM_MBOX)) u_sticky (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .set_in(mbox_evt_q),
    .clr_wr_in(clr_wr),
    .clr_in(wdata & byte_mask),
    .en_wr_in(en_wr),
    .en_in((irq_enable & ~byte_mask) | (wdata & byte_mask)),
    .status_out(irq_status),
    .enable_out(irq_enable),
    .irq_out(IRQ_OUT)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    flags_word = 16'h0000; // [R1]
    flags_word[cmi_pkg::CMI_BIT_EMPTY] = flags_q.empty;
    flags_word[cmi_pkg::CMI_BIT_UNREAD] = flags_q.unread;
    flags_word[cmi_pkg::CMI_BIT_RXMSG] = flags_q.rx_msg;
    rd_word = 16'h0000;
    if (hit_flags) begin
      rd_word = flags_word;
    end else if (hit_mbox) begin
      rd_word = mbox_mask_q;
    end else if (hit_gen) begin
      rd_word = gen_mask_q;
    end else if (hit_stat) begin
      rd_word = irq_status;
    end else if (hit_en) begin
      rd_word = irq_enable;
    end
    ack_d = bus_req;
    dat_d = bus_req ? {16'h0000, rd_word} : 32'h0000_0000;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign WB_ACK_OUT = ack_q;
  assign WB_DAT_OUT = dat_q;
  assign UNREAD_REQ_OUT = req_q.unread;
  assign EMPTY_REQ_OUT = req_q.empty;
  assign RXMSG_REQ_OUT = req_q.rx_msg;
  assign MBOX_EVT_OUT = mbox_evt_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_RSVD_ZERO: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) // [R1]
    ack_q && !WB_WE_IN && hit_flags |-> WB_DAT_OUT[3:2] == 2'b00)
    else $error("reserved flag bits read nonzero");

  AST_UNREAD_SET: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) // [R3]
    (|um_rise) |=> flags_q.unread
      ##1 UNREAD_REQ_OUT == !$past(gen_mask_q[cmi_pkg::CMI_GM_UNREAD]))
    else $error("unread flag missed a status set");

  AST_UNREAD_HOLD: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) // [R4]
    flags_q.unread && mbox_in.unread != 16'h0000 |=> flags_q.unread)
    else $error("unread flag cleared while status bits remain");

  AST_UNREAD_CLR: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) // [R4]
    mbox_in.unread == 16'h0000 |=> !flags_q.unread)
    else $error("unread flag stuck after status cleared");

  AST_EMPTY_SET: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) // [R6]
    (|tx_fall) |=> flags_q.empty)
    else $error("empty flag missed a pending clear");

  AST_EMPTY_KEEP: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) // [R7]
    flags_q.empty && !empty_clr |=> flags_q.empty)
    else $error("empty flag lost without a one-write");

  AST_EMPTY_CLR: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) // [R7]
    empty_clr && !(|tx_fall) |=> !flags_q.empty)
    else $error("one-write failed to clear empty flag");

  AST_MBOX_BLOCK: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) // [R10]
    1'b1 |=> (MBOX_EVT_OUT & $past(mbox_mask_vec)) == 16'h0000)
    else $error("masked mailbox raised an event");

  AST_TX_PASS: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) // [R9] [R11]
    (|(tx_fall & ~mbox_mask_vec)) |=> (|MBOX_EVT_OUT) ##1 (|irq_status))
    else $error("unmasked transmit end gave no event");

  AST_RX_PASS: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) // [R12] [R14]
    (|(rx_rise & ~mbox_mask_vec)) |=> (|MBOX_EVT_OUT) && flags_q.rx_msg)
    else $error("unmasked reception gave no event");

  AST_GEN_MASK: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN) // [R13] [R16]
    ##1 EMPTY_REQ_OUT == ($past(flags_q.empty) && !$past(gen_mask_q[0])))
    else $error("empty request disagrees with flag and mask");

  AST_MASK_RESET: assert property (@(posedge SYS_CLK_IN) // [R15]
    $fell(RST_IN) |-> mbox_mask_q == 16'hffff && mbox_mask_vec == 16'hffff)
    else $error("mailbox mask not all ones after reset");

endmodule : cmi_top
`default_nettype wire

//--- pkg/cmi_pkg.sv
`default_nettype none
package cmi_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned CMI_NUM_MBOX = 16;
  localparam int unsigned CMI_ADR_W = 8;
  localparam int unsigned CMI_REG_W = 16;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] CMI_OFF_FLAGS = 8'h00;
  localparam logic [7:0] CMI_OFF_MBOX_MASK = 8'h04;
  localparam logic [7:0] CMI_OFF_GEN_MASK = 8'h08;
  localparam logic [7:0] CMI_OFF_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] CMI_OFF_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] CMI_OFF_IRQ_ENABLE = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CMI_BIT_EMPTY = 0;
  localparam int unsigned CMI_BIT_UNREAD = 1;
  localparam int unsigned CMI_BIT_RXMSG = 9;
  localparam int unsigned CMI_GM_EMPTY = 0;
  localparam int unsigned CMI_GM_UNREAD = 1;
  localparam int unsigned CMI_GM_RXMSG = 9;

  // ----------------------------------------------------------------
  // Reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [15:0] CMI_MBOX_MASK_RST = 16'hffff;
  localparam logic [15:0] CMI_GEN_MASK_RST = 16'hfeff;
  localparam logic [15:0] CMI_GEN_MASK_WR = 16'h0203;
  localparam logic [15:0] CMI_IRQ_EN_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rx_msg;
    logic unread;
    logic empty;
  } cmi_flags_t;

  typedef struct packed {
    logic [15:0] tx_pend;
    logic [15:0] rx_done;
    logic [15:0] unread;
  } cmi_mbox_t;

endpackage : cmi_pkg
`default_nettype wire

//--- src/cmi_edge.sv
`timescale 1ns/1ps
`default_nettype none
module cmi_edge #(
  parameter int unsigned W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] sig_in,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);

  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  always_comb begin
    prev_d = sig_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

  // ----------------------------------------------------------------
  // Per-bit transitions
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign rise_out[i] = sig_in[i] & ~prev_q[i];
      assign fall_out[i] = ~sig_in[i] & prev_q[i];
    end
  endgenerate

endmodule : cmi_edge
`default_nettype wire

//--- src/cmi_sticky.sv
`timescale 1ns/1ps
`default_nettype none
module cmi_sticky #(
  parameter int unsigned W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] set_in,
  input wire logic clr_wr_in,
  input wire logic [W-1:0] clr_in,
  input wire logic en_wr_in,
  input wire logic [W-1:0] en_in,
  output logic [W-1:0] status_out,
  output logic [W-1:0] enable_out,
  output logic irq_out
);

  logic [W-1:0] status_q;
  logic [W-1:0] status_d;
  logic [W-1:0] enable_q;
  logic [W-1:0] enable_d;
  logic irq_q;
  logic irq_d;

  // Set beats a clear landing in the same cycle
  always_comb begin
    status_d = status_q;
    if (clr_wr_in) begin
      status_d = status_q & ~clr_in;
    end
    status_d = status_d | set_in;
    enable_d = en_wr_in ? en_in : enable_q;
    irq_d = |(status_q & enable_q);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status_q <= '0;
      enable_q <= W'(cmi_pkg::CMI_IRQ_EN_RST);
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      enable_q <= enable_d;
      irq_q <= irq_d;
    end
  end

  assign status_out = status_q;
  assign enable_out = enable_q;
  assign irq_out = irq_q;

endmodule : cmi_sticky
`default_nettype wire

//--- testbench/cmi_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module cmi_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [15:0] tx = 16'h0028;
  logic [15:0] rx = 16'h0000;
  logic [15:0] unr = 16'h0000;
  logic unr_req, emp_req, rxm_req, irq;
  logic [15:0] evt;
  logic [15:0] q;
  logic [3:0] lanes = 4'h3;
  int n_mismatch = 0;
  int num_checks = 0;

  always #10 clk = ~clk;

  cmi_top DUT (
    .SYS_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .TX_PENDING_BITS_IN(tx), .RX_COMPLETE_BITS_IN(rx),
    .UNREAD_STATUS_IN(unr), .UNREAD_REQ_OUT(unr_req), .EMPTY_REQ_OUT(emp_req),
    .RXMSG_REQ_OUT(rxm_req), .MBOX_EVT_OUT(evt), .IRQ_OUT(irq)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Reads in the active region see values sampled at this edge
  task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      print_verdict();
    end else begin
      q = rdat[15:0];
      check(rdat[31:16], 32'h0);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask : wb

  task rd(input logic [7:0] a, input logic [15:0] exp);
    wb(1'b0, a, 16'h0000);
    check(q, exp);
  endtask : rd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task s_reset;
    rd(8'h00, 16'h0000);
    rd(8'h04, 16'hffff);
    rd(8'h08, 16'hfeff);
    rd(8'h0c, 16'h0000);
    wb(1'b1, 8'h20, 16'h0000);
    rd(8'h20, 16'h0000);
    rd(8'h04, 16'hffff);
    check({unr_req, emp_req, rxm_req, irq}, 4'h0);
  endtask : s_reset

  task s_tx;
    // Mailbox 3 sits at bit 11, mailbox 10 at bit 2
    wb(1'b1, 8'h04, 16'hf7fb);
    rd(8'h04, 16'hf7fb);
    @(posedge clk);
    tx <= 16'h0008;
    tick(2);
    check(evt, 16'h0000);
    rd(8'h00, 16'h0001);
    check(emp_req, 1'b0);
    wb(1'b1, 8'h00, 16'h0000);
    rd(8'h00, 16'h0001);
    wb(1'b1, 8'h00, 16'hfff3);
    rd(8'h00, 16'h0000);
    @(posedge clk);
    tx <= 16'h0000;
    tick(2);
    check(evt, 16'h0008);
    tick(1);
    check(evt, 16'h0000);
    rd(8'h00, 16'h0001);
    wb(1'b1, 8'h08, 16'h0000);
    rd(8'h08, 16'hfcfc);
    tick(3);
    check(emp_req, 1'b1);
    wb(1'b1, 8'h08, 16'h0001);
    tick(3);
    check(emp_req, 1'b0);
    wb(1'b1, 8'h08, 16'h0000);
    wb(1'b1, 8'h00, 16'h0001);
    tick(3);
    check(emp_req, 1'b0);
  endtask : s_tx

  task s_unread;
    @(posedge clk);
    unr <= 16'h0040;
    tick(3);
    rd(8'h00, 16'h0002);
    check(unr_req, 1'b1);
    wb(1'b1, 8'h00, 16'hfff3);
    rd(8'h00, 16'h0002);
    unr <= 16'h0041;
    tick(2);
    unr <= 16'h0001;
    tick(3);
    rd(8'h00, 16'h0002);
    unr <= 16'h0000;
    tick(3);
    rd(8'h00, 16'h0000);
    tick(1);
    check(unr_req, 1'b0);
  endtask : s_unread

  task s_rx;
    @(posedge clk);
    rx <= 16'h1000;
    tick(2);
    check(evt, 16'h0000);
    rd(8'h00, 16'h0000);
    @(posedge clk);
    rx <= 16'h1400;
    tick(2);
    check(evt, 16'h0400);
    rd(8'h00, 16'h0200);
    check(rxm_req, 1'b1);
    rx <= 16'h0000;
    tick(3);
    rd(8'h00, 16'h0000);
  endtask : s_rx

  task s_irq;
    rd(8'h0c, 16'h0408);
    check(irq, 1'b0);
    wb(1'b1, 8'h14, 16'h0008);
    rd(8'h14, 16'h0008);
    tick(3);
    check(irq, 1'b1);
    wb(1'b1, 8'h10, 16'h0008);
    rd(8'h10, 16'h0000);
    rd(8'h0c, 16'h0400);
    tick(3);
    check(irq, 1'b0);
    wb(1'b1, 8'h14, 16'h0400);
    tick(3);
    check(irq, 1'b1);
    wb(1'b1, 8'h10, 16'h0400);
    tick(3);
    check(irq, 1'b0);
    // Low byte lane only: high byte of the mask must survive
    lanes = 4'h1;
    wb(1'b1, 8'h04, 16'h0000);
    lanes = 4'h3;
    rd(8'h04, 16'hf700);
  endtask : s_irq

  // Reset in mid-run must bring the flag, mask and status registers back
  task s_midreset;
    @(posedge clk);
    rst <= 1'b1;
    tick(16);
    rst <= 1'b0;
    s_reset();
  endtask : s_midreset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(16);
    rst <= 1'b0;
    s_reset();
    s_tx();
    s_unread();
    s_rx();
    s_irq();
    s_midreset();
    tick(2);
    print_verdict();
  end
endmodule : cmi_top_test
`default_nettype wire
